// *** hw/pco_pkg.sv ***
package pco_pkg;

  // unit count and width of the axis select on the register port
  localparam int AXES = 2;
  localparam int AXIS_W = 1;
  localparam int NUM_GPO = 4;

  // register offsets, as printed (parameter numbers, not byte addresses)
  localparam logic [11:0] ADDR_CFG = 12'h185;
  localparam logic [11:0] ADDR_STATUS = 12'h186;
  localparam logic [11:0] ADDR_VALUE0 = 12'h187;
  localparam logic [11:0] ADDR_VALUE1 = 12'h188;
  localparam logic [11:0] ADDR_INCR = 12'h189;
  localparam logic [11:0] ADDR_PERIOD = 12'h18a;

  // configuration field positions
  localparam int CFG_ENABLE_BIT = 0;
  localparam int CFG_INVERT_BIT = 1;
  localparam int CFG_TOGGLE_BIT = 2;
  localparam int CFG_MODE_LSB = 3;
  localparam int CFG_SRC_LSB = 16;
  localparam logic [31:0] CFG_MASK = 32'h0003_001f;

  // status field positions
  localparam int STAT_LEVEL_BIT = 0;
  localparam int STAT_HIT0_BIT = 1;
  localparam int STAT_HIT1_BIT = 2;

  // pulse period field width
  localparam int PULSE_W = 20;

  // reset values
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic [31:0] VALUE_RESET = 32'h0000_0000;
  localparam logic [19:0] PERIOD_RESET = 20'h0_0000;

  // output pin function code that follows the compare output
  localparam logic [7:0] GPO_FUNC_FOLLOW = 8'h10;

  // pulse timing: period counts 10 ns units, the clock is 20 ns
  localparam int CLK_PERIOD_NS = 20;
  localparam int PULSE_UNIT_NS = 10;
  localparam int UNITS_PER_CLK = CLK_PERIOD_NS / PULSE_UNIT_NS;

  typedef enum logic [1:0] {
    PCO_MODE_DUAL,
    PCO_MODE_SINGLE,
    PCO_MODE_WINDOW,
    PCO_MODE_SINGLE_END
  } pco_mode_t;

  typedef enum logic [1:0] {
    PCO_SRC_LOOP,
    PCO_SRC_MOTOR,
    PCO_SRC_LOAD,
    PCO_SRC_RSVD
  } pco_src_t;

endpackage

// *** hw/pco_position_compare.sv ***
`timescale 1ns/1ps
`default_nettype none

// Function
// - follow-code output pins copy compare level
// - one compare unit per axis, two axes
// - enable bit gates all comparing
// - invert bit flips output active level
// - toggle on match, else timed pulse
// - mode field at bits 3-4
// - source select at bits 16-17, 3 reserved
// - source zero uses position loop encoder
// - source one uses motor encoder
// - source two uses load encoder
// - status bit 0 shows output, read-only
// - match flags sticky, write one clears
// - signed increment updates compare values
// - pulse length low 20 bits, 10 ns
// - dual mode moves opposite value by increment
// - single mode compares value 0, adds increment
// - window mode: above value 0, up to value 1
// - single-end mode disables past value 1
module pco_position_compare
  import pco_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // register port
  input wire logic [AXIS_W-1:0] reg_axis,
  input wire logic [11:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  // encoder positions per axis
  input wire logic [AXES-1:0][31:0] pos_loop,
  input wire logic [AXES-1:0][31:0] pos_motor,
  input wire logic [AXES-1:0][31:0] pos_load,
  // compare outputs per axis
  output logic [AXES-1:0] cmp_level,
  // general purpose output pins
  input wire logic [NUM_GPO-1:0][7:0] gpo_func,
  input wire logic [NUM_GPO-1:0][AXIS_W-1:0] gpo_axis,
  input wire logic [NUM_GPO-1:0] gpo_fw_level,
  output logic [NUM_GPO-1:0] gpo_level
);

  //////////////////////////////////////////////////////////////////////////////
  // per-axis register storage

  logic [31:0] cfg_r [AXES];
  logic signed [31:0] val0_r [AXES];
  logic signed [31:0] val1_r [AXES];
  logic signed [31:0] incr_r [AXES];
  logic [PULSE_W-1:0] period_r [AXES];
  logic [AXES-1:0] hit0_flag_r;
  logic [AXES-1:0] hit1_flag_r;
  logic [AXES-1:0] level_r;
  logic [31:0] rdata_r;
  logic rvalid_r;
  logic [NUM_GPO-1:0] gpo_r;

  //////////////////////////////////////////////////////////////////////////////
  // one compare unit per axis

  generate
    for (genvar a = 0; a < AXES; a++) begin : g_axis
      logic wr_sel;
      logic signed [31:0] pos;
      logic signed [31:0] prev_r;
      logic prev_ok_r;
      logic en;
      logic inv;
      logic toggle;
      pco_mode_t mode;
      pco_src_t src;
      logic up0, dn0, up1, dn1;
      logic hit0, hit1;
      logic fire;
      logic stop;
      logic in_window;
      logic raw_r;
      logic [PULSE_W:0] cnt_r;

      assign wr_sel = reg_wr && (reg_axis == AXIS_W'(a));

      // configuration fields
      assign en = cfg_r[a][CFG_ENABLE_BIT];
      assign inv = cfg_r[a][CFG_INVERT_BIT];
      assign toggle = cfg_r[a][CFG_TOGGLE_BIT];
      assign mode = pco_mode_t'(cfg_r[a][CFG_MODE_LSB +: 2]);
      assign src = pco_src_t'(cfg_r[a][CFG_SRC_LSB +: 2]);

      // encoder source; the reserved code falls back to the loop encoder
      always_comb begin
        unique case (src)
          PCO_SRC_LOOP: pos = $signed(pos_loop[a]);
          PCO_SRC_MOTOR: pos = $signed(pos_motor[a]);
          PCO_SRC_LOAD: pos = $signed(pos_load[a]);
          PCO_SRC_RSVD: pos = $signed(pos_loop[a]);
        endcase
      end

      // positions are taken as same-domain counts; a foreign source needs syncing outside
      // previous sample; invalid while disabled so enabling never fakes a crossing
      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          prev_r <= VALUE_RESET;
          prev_ok_r <= 1'b0;
        end else begin
          prev_r <= pos;
          prev_ok_r <= en;
        end
      end

      // a jump across the signed wrap point looks like a real crossing, so
      // wrapped encoder counts are not supported on a compare source
      // crossings in each direction; equality counts as being at or above the value
      assign up0 = en && prev_ok_r && (prev_r < val0_r[a]) && (pos >= val0_r[a]);
      assign dn0 = en && prev_ok_r && (prev_r >= val0_r[a]) && (pos < val0_r[a]);
      assign up1 = en && prev_ok_r && (prev_r < val1_r[a]) && (pos >= val1_r[a]);
      assign dn1 = en && prev_ok_r && (prev_r >= val1_r[a]) && (pos < val1_r[a]);
      assign hit0 = up0 || dn0;
      assign hit1 = up1 || dn1;
      assign in_window = (pos > val0_r[a]) && (pos <= val1_r[a]);

      // output events per mode
      always_comb begin
        unique case (mode)
          PCO_MODE_DUAL: fire = hit0 || hit1;
          PCO_MODE_SINGLE: fire = hit0;
          PCO_MODE_WINDOW: fire = 1'b0;
          PCO_MODE_SINGLE_END: fire = hit0;
        endcase
      end
      assign stop = hit1 && (mode == PCO_MODE_SINGLE_END);

      // otherwise a write that re-enables could be lost to a late stop
      // configuration; a software write beats the automatic disable
      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          cfg_r[a] <= CFG_RESET;
        end else if (wr_sel && reg_addr == ADDR_CFG) begin
          cfg_r[a] <= reg_wdata & CFG_MASK;
        end else if (stop) begin
          cfg_r[a][CFG_ENABLE_BIT] <= 1'b0;
        end
      end

      // one update per sample: a move past several steps between samples
      // shifts the value once, so the source must move less than one step
      // value 0: software write, else hardware update
      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          val0_r[a] <= VALUE_RESET;
        end else if (wr_sel && reg_addr == ADDR_VALUE0) begin
          val0_r[a] <= reg_wdata;
        end else if (mode == PCO_MODE_DUAL) begin
          if (up1) begin
            val0_r[a] <= val0_r[a] + incr_r[a];
          end else if (dn1) begin
            val0_r[a] <= val0_r[a] - incr_r[a];
          end
        end else if (mode != PCO_MODE_WINDOW && hit0) begin
          val0_r[a] <= val0_r[a] + incr_r[a];
        end
      end

      // value 1 moves only in dual mode
      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          val1_r[a] <= VALUE_RESET;
        end else if (wr_sel && reg_addr == ADDR_VALUE1) begin
          val1_r[a] <= reg_wdata;
        end else if (mode == PCO_MODE_DUAL) begin
          if (up0) begin
            val1_r[a] <= val1_r[a] + incr_r[a];
          end else if (dn0) begin
            val1_r[a] <= val1_r[a] - incr_r[a];
          end
        end
      end

      // increment and pulse period
      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          incr_r[a] <= VALUE_RESET;
          period_r[a] <= PERIOD_RESET;
        end else begin
          if (wr_sel && reg_addr == ADDR_INCR) begin
            incr_r[a] <= reg_wdata;
          end
          if (wr_sel && reg_addr == ADDR_PERIOD) begin
            period_r[a] <= reg_wdata[PULSE_W-1:0];
          end
        end
      end

      // each flag clears on its own bit, so they can be acknowledged apart
      // sticky match flags; a match in the clearing cycle survives
      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          hit0_flag_r[a] <= 1'b0;
          hit1_flag_r[a] <= 1'b0;
        end else begin
          hit0_flag_r[a] <= hit0 || (hit0_flag_r[a] &&
            !(wr_sel && reg_addr == ADDR_STATUS && reg_wdata[STAT_HIT0_BIT]));
          hit1_flag_r[a] <= hit1 || (hit1_flag_r[a] &&
            !(wr_sel && reg_addr == ADDR_STATUS && reg_wdata[STAT_HIT1_BIT]));
        end
      end

      // the timer steps two units a clock, so odd periods round up a clock;
      // finer steps would need a faster clock than this block has
      // raw output and pulse timer; each clock is two 10 ns units
      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          raw_r <= 1'b0;
          cnt_r <= '0;
        end else if (!en) begin
          raw_r <= 1'b0;
          cnt_r <= '0;
        end else if (mode == PCO_MODE_WINDOW) begin
          raw_r <= in_window;
          cnt_r <= '0;
        end else if (fire) begin
          raw_r <= toggle ? !raw_r : 1'b1;
          cnt_r <= (PULSE_W+1)'(UNITS_PER_CLK);
        end else if (!toggle && raw_r) begin
          if (cnt_r >= {1'b0, period_r[a]}) begin
            raw_r <= 1'b0;
          end else begin
            cnt_r <= cnt_r + (PULSE_W+1)'(UNITS_PER_CLK);
          end
        end
      end

      // polarity applied last so both pulse and toggle obey it
      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          level_r[a] <= 1'b0;
        end else begin
          level_r[a] <= raw_r ^ inv;
        end
      end
    end
  endgenerate

  assign cmp_level = level_r;

  //////////////////////////////////////////////////////////////////////////////
  // read data holds between reads, so a slow master may take it late
  // register read: one cycle after the strobe; unmapped reads return zero

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_r <= 32'h0000_0000;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= reg_rd;
      if (reg_rd) begin
        unique case (reg_addr)
          ADDR_CFG: rdata_r <= cfg_r[reg_axis];
          ADDR_STATUS: rdata_r <= {29'h0000_0000, hit1_flag_r[reg_axis],
            hit0_flag_r[reg_axis], level_r[reg_axis]};
          ADDR_VALUE0: rdata_r <= val0_r[reg_axis];
          ADDR_VALUE1: rdata_r <= val1_r[reg_axis];
          ADDR_INCR: rdata_r <= incr_r[reg_axis];
          ADDR_PERIOD: rdata_r <= {12'h000, period_r[reg_axis]};
          default: rdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign reg_rdata = rdata_r;
  assign reg_rvalid = rvalid_r;

  //////////////////////////////////////////////////////////////////////////////
  // pins lag the compare output by one clock, the price of a registered pin
  // output pins: follow code takes the compare level of the chosen axis

  generate
    for (genvar p = 0; p < NUM_GPO; p++) begin : g_gpo
      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          gpo_r[p] <= 1'b0;
        end else if (gpo_func[p] == GPO_FUNC_FOLLOW) begin
          gpo_r[p] <= level_r[gpo_axis[p]];
        end else begin
          gpo_r[p] <= gpo_fw_level[p];
        end
      end
    end
  endgenerate

  assign gpo_level = gpo_r;

endmodule

`default_nettype wire

// *** testbench/pco_enc_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module pco_enc_model
  import pco_pkg::*;
(
  // clock
  input wire logic sys_clk,
  // encoder positions per axis
  output var logic [AXES-1:0][31:0] pos_loop,
  output var logic [AXES-1:0][31:0] pos_motor,
  output var logic [AXES-1:0][31:0] pos_load
);
  // all encoders power up at zero counts
  initial begin
    pos_loop = '0;
    pos_motor = '0;
    pos_load = '0;
  end
  // a new count lands just after an edge, as from a counter in the same domain
  task automatic put(input pco_src_t src, input int ax, input logic [31:0] val);
    @(posedge sys_clk);
    case (src)
      PCO_SRC_MOTOR: pos_motor[ax] <= val;
      PCO_SRC_LOAD: pos_load[ax] <= val;
      default: pos_loop[ax] <= val;
    endcase
  endtask
endmodule
`default_nettype wire

// *** testbench/pco_position_compare_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module pco_position_compare_monitor
  import pco_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // register port
  input wire logic [11:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rvalid,
  // compare outputs and pins
  input wire logic [AXES-1:0] cmp_level,
  input wire logic [NUM_GPO-1:0][7:0] gpo_func,
  input wire logic [NUM_GPO-1:0][AXIS_W-1:0] gpo_axis,
  input wire logic [NUM_GPO-1:0] gpo_fw_level,
  input wire logic [NUM_GPO-1:0] gpo_level
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  logic [AXES-1:0] cmp_r;
  // pins lag the compare output by one register, so keep last cycle's level
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cmp_r <= '0;
    end else begin
      cmp_r <= cmp_level;
    end
  end
  sequence s_rd(logic [11:0] a);
    reg_rd && reg_addr == a;
  endsequence
  //////////////////////////////////////////////////////////////
  chk_read_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read strobe got no answer");
  chk_rvalid_cause: assert property (!reg_rd |=> !reg_rvalid)
    else $error("read answer without strobe");
  chk_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");
  chk_cfg_reserved: assert property (s_rd(ADDR_CFG) |=> (reg_rdata & ~CFG_MASK) == 32'h0)
    else $error("reserved config bits read nonzero");
  chk_period_width: assert property (s_rd(ADDR_PERIOD) |=> reg_rdata[31:20] == 12'h000)
    else $error("period upper bits read nonzero");
  chk_status_spare: assert property (s_rd(ADDR_STATUS) |=> reg_rdata[31:3] == 29'h0)
    else $error("status spare bits read nonzero");
  chk_unmapped_zero: assert property
    (reg_rd && (reg_addr < ADDR_CFG || reg_addr > ADDR_PERIOD) |=> reg_rdata == 32'h0)
    else $error("unmapped read nonzero");
  for (genvar g = 0; g < NUM_GPO; g++) begin : g_pin
    chk_pin_follow: assert property
      ($past(reset_n, 2) && $past(gpo_func[g]) == GPO_FUNC_FOLLOW
        |-> gpo_level[g] == cmp_r[$past(gpo_axis[g])])
      else $error("follow pin does not copy compare level");
    chk_pin_firmware: assert property
      ($past(reset_n, 2) && $past(gpo_func[g]) != GPO_FUNC_FOLLOW
        |-> gpo_level[g] == $past(gpo_fw_level[g]))
      else $error("firmware pin level wrong");
  end
endmodule
bind pco_position_compare pco_position_compare_monitor i_mon (.sys_clk, .reset_n, .reg_addr,
  .reg_rd, .reg_rdata, .reg_rvalid, .cmp_level, .gpo_func, .gpo_axis, .gpo_fw_level, .gpo_level);
`default_nettype wire

// *** testbench/position_compare_output_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(act, exp) begin \
  total_checks++; \
  if ((act) !== (exp)) begin \
    fails++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, act, exp); \
  end \
end
module position_compare_output_tb_top
  import pco_pkg::*;
;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [AXIS_W-1:0] reg_axis;
  logic [11:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic reg_rvalid;
  logic [AXES-1:0][31:0] pos_loop;
  logic [AXES-1:0][31:0] pos_motor;
  logic [AXES-1:0][31:0] pos_load;
  logic [AXES-1:0] cmp_level;
  logic [NUM_GPO-1:0][7:0] gpo_func;
  logic [NUM_GPO-1:0][AXIS_W-1:0] gpo_axis;
  logic [NUM_GPO-1:0] gpo_fw_level;
  logic [NUM_GPO-1:0] gpo_level;
  logic [31:0] d;
  int fails = 0;
  int total_checks = 0;
  int cyc = 0;
  logic [31:0] n;
  int win_pos[4] = '{55, 61, 60, 50};
  logic win_exp[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  // 50 MHz system clock
  always #10 sys_clk = ~sys_clk;
  pco_position_compare i_pco_position_compare (.sys_clk, .reset_n, .reg_axis, .reg_addr,
    .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid, .pos_loop, .pos_motor, .pos_load,
    .cmp_level, .gpo_func, .gpo_axis, .gpo_fw_level, .gpo_level);
  pco_enc_model i_pco_enc_model (.sys_clk, .pos_loop, .pos_motor, .pos_load);
  //////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks=%0d fails=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // whole run is about 150 cycles; a hang stops at this ceiling of 5000, far above that
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      finish_test();
    end
  end
  // one strobe cycle per write
  task automatic wr(input logic [AXIS_W-1:0] ax, input logic [11:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_axis <= ax;
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // answer is due exactly one cycle after the strobe edge
  task automatic rd(input logic [AXIS_W-1:0] ax, input logic [11:0] a);
    @(posedge sys_clk);
    reg_axis <= ax;
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rvalid, 1'b1)
    d = reg_rdata;
  endtask
  task automatic rdc(input logic [AXIS_W-1:0] ax, input logic [11:0] a, input logic [31:0] e);
    rd(ax, a);
    `CHK(d, e)
  endtask
  initial begin
    reg_axis = '0;
    reg_addr = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = '0;
    gpo_func = {8'h00, 8'h00, GPO_FUNC_FOLLOW, GPO_FUNC_FOLLOW};
    gpo_axis = {1'b0, 1'b0, 1'b1, 1'b0};
    gpo_fw_level = 4'b1010;
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    wr(0, ADDR_CFG, 32'hffff_fffe);
    rdc(0, ADDR_CFG, 32'h0003_001e);
    wr(0, ADDR_PERIOD, 32'hffff_ffff);
    rdc(0, ADDR_PERIOD, 32'h000f_ffff);
    wr(0, ADDR_INCR, 32'hffff_fff6);
    rdc(0, ADDR_INCR, 32'hffff_fff6);
    rdc(0, 12'h190, 32'h0000_0000);
    wr(0, ADDR_CFG, 32'h0000_0000);
    i_pco_enc_model.put(PCO_SRC_LOOP, 0, 32'd100);
    wr(0, ADDR_STATUS, 32'h0000_0001);
    rdc(0, ADDR_STATUS, 32'h0000_0000);
    $display("test registers done");
    // mode 1, pulse of 4 units from the loop encoder
    wr(0, ADDR_PERIOD, 32'h0000_0004);
    wr(0, ADDR_VALUE0, 32'd10);
    wr(0, ADDR_INCR, 32'd5);
    i_pco_enc_model.put(PCO_SRC_LOOP, 0, 32'd8);
    wr(0, ADDR_CFG, 32'h0000_0009);
    repeat (2) @(posedge sys_clk);
    i_pco_enc_model.put(PCO_SRC_LOOP, 0, 32'd9);
    i_pco_enc_model.put(PCO_SRC_LOOP, 0, 32'd10);
    n = 0;
    repeat (8) begin
      @(posedge sys_clk);
      #1;
      n += cmp_level[0];
    end
    `CHK(n, 32'd2)
    rdc(0, ADDR_VALUE0, 32'd15);
    rd(0, ADDR_STATUS);
    `CHK(d & 32'h6, 32'h2)
    wr(0, ADDR_STATUS, 32'h0000_0002);
    rd(0, ADDR_STATUS);
    `CHK(d & 32'h6, 32'h0)
    $display("test pulse done");
    // mode 0, toggled and inverted, motor encoder
    wr(0, ADDR_CFG, 32'h0000_0000);
    i_pco_enc_model.put(PCO_SRC_MOTOR, 0, 32'd150);
    wr(0, ADDR_VALUE0, 32'd100);
    wr(0, ADDR_VALUE1, 32'd200);
    wr(0, ADDR_INCR, 32'd300);
    wr(0, ADDR_CFG, 32'h0001_0007);
    repeat (3) @(posedge sys_clk);
    #1;
    `CHK(cmp_level[0], 1'b1)
    i_pco_enc_model.put(PCO_SRC_MOTOR, 0, 32'd210);
    repeat (4) @(posedge sys_clk);
    #1;
    `CHK(cmp_level[0], 1'b0)
    rdc(0, ADDR_VALUE0, 32'd400);
    i_pco_enc_model.put(PCO_SRC_MOTOR, 0, 32'd150);
    repeat (4) @(posedge sys_clk);
    #1;
    `CHK(cmp_level[0], 1'b1)
    rdc(0, ADDR_VALUE0, 32'd100);
    // value 1 was crossed twice; clearing its flag must leave the level bit alone
    rdc(0, ADDR_STATUS, 32'h0000_0005);
    wr(0, ADDR_STATUS, 32'h0000_0004);
    rdc(0, ADDR_STATUS, 32'h0000_0001);
    $display("test dual done");
    // mode 2 window on the second axis, load encoder
    wr(1, ADDR_VALUE0, 32'd50);
    wr(1, ADDR_VALUE1, 32'd60);
    wr(1, ADDR_CFG, 32'h0002_0011);
    for (int i = 0; i < 4; i++) begin
      i_pco_enc_model.put(PCO_SRC_LOAD, 1, win_pos[i]);
      repeat (4) @(posedge sys_clk);
      #1;
      `CHK(cmp_level[1], win_exp[i])
      `CHK(gpo_level[1], win_exp[i])
    end
    // pin 0 follows the inverted axis 0 level, pins 2 and 3 keep firmware levels
    `CHK(gpo_level, 4'b1001)
    $display("test window done");
    // mode 3 stops itself past value 1
    wr(0, ADDR_CFG, 32'h0000_0000);
    i_pco_enc_model.put(PCO_SRC_LOOP, 0, 32'd5);
    wr(0, ADDR_VALUE0, 32'd10);
    wr(0, ADDR_VALUE1, 32'd20);
    wr(0, ADDR_INCR, 32'd5);
    wr(0, ADDR_CFG, 32'h0000_0019);
    repeat (2) @(posedge sys_clk);
    i_pco_enc_model.put(PCO_SRC_LOOP, 0, 32'd12);
    repeat (2) @(posedge sys_clk);
    i_pco_enc_model.put(PCO_SRC_LOOP, 0, 32'd21);
    repeat (4) @(posedge sys_clk);
    rdc(0, ADDR_CFG, 32'h0000_0018);
    rdc(0, ADDR_VALUE0, 32'd20);
    $display("test end mode done");
    // a reset in mid-run brings every output and register back to zero
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    `CHK({cmp_level, gpo_level, reg_rvalid}, 7'h00)
    @(posedge sys_clk);
    reset_n <= 1'b1;
    rdc(0, ADDR_CFG, 32'h0000_0000);
    rdc(1, ADDR_VALUE1, 32'h0000_0000);
    `CHK(cmp_level, 2'b00)
    $display("test reset done");
    finish_test();
  end
endmodule
`default_nettype wire
